// ==== pkg/fbo_pkg.sv ====
package fbo_pkg;
    localparam int SAMPLE_W = 32;
    localparam int MAX_OVS = 8;
    localparam logic [31:0] AB_TOGGLE = 32'h0503_0000;
    localparam logic [31:0] AB_TIMEOUT = 32'h0504_0000;
    localparam logic [31:0] AB_ACCESS = 32'h0601_0000;
    localparam logic [31:0] AB_READ_WO = 32'h0601_0001;
    localparam logic [31:0] AB_WRITE_RO = 32'h0601_0002;
    localparam logic [31:0] AB_NO_OBJ = 32'h0602_0000;
    localparam logic [31:0] AB_NOT_MAP = 32'h0604_0041;
    localparam logic [31:0] AB_MAP_LEN = 32'h0604_0042;
    localparam logic [31:0] AB_HW = 32'h0606_0000;
    localparam logic [31:0] AB_LEN = 32'h0607_0010;
    localparam logic [31:0] AB_LONG = 32'h0607_0012;
    localparam logic [31:0] AB_SHORT = 32'h0607_0013;
    localparam logic [31:0] AB_NO_SUB = 32'h0609_0011;
    localparam logic [31:0] AB_VALUE = 32'h0609_0030;
    localparam logic [31:0] AB_HIGH = 32'h0609_0031;
    localparam logic [31:0] AB_LOW = 32'h0609_0032;
    localparam logic [31:0] AB_MAXMIN = 32'h0609_0036;
    localparam logic [31:0] AB_STORE = 32'h0800_0020;
    localparam logic [31:0] AB_LOCAL = 32'h0800_0021;
    localparam logic [31:0] AB_STATE = 32'h0800_0022;
    localparam logic [31:0] AB_DIR = 32'h0800_0023;
    localparam int ERR_W = 21;
    typedef enum logic [4:0] {
        E_TOGGLE, E_TIMEOUT, E_ACCESS, E_READ_WO, E_WRITE_RO, E_NO_OBJ,
        E_NOT_MAP, E_MAP_LEN, E_HW, E_LEN, E_LONG, E_SHORT, E_NO_SUB,
        E_VALUE, E_HIGH, E_LOW, E_MAXMIN, E_STORE, E_LOCAL, E_STATE, E_DIR
    } fbo_err_t;
    localparam int TIMEOUT_NS = 100000;
    localparam int CLK_NS = 5;
    localparam int TIMEOUT_CYC = TIMEOUT_NS / CLK_NS;
    localparam logic [1:0] SEL_RST = 2'h0;
endpackage : fbo_pkg

// ==== rtl/fbo_framer.sv ====
`timescale 1ns/10ps
// Operation
// R1 - Any failed mailbox request ends with an abort carrying a 32-bit cause code
// R2 - Unchanged segment toggle bit aborts with the toggle code
// R3 - Transfer not finished before timeout aborts with the timeout code
// R4 - Unsupported access, read of write-only, write of read-only: own codes
// R5 - Index missing from the object directory aborts with object-absent code
// R6 - Non-mappable object or oversized mapping each abort with own code
// R7 - Hardware fault blocking access aborts with the hardware code
// R8 - Type or length mismatch aborts with generic, too-long or too-short code
// R9 - Missing sub-index of existing object aborts with its code
// R10 - Invalid write value aborts; too high or too low use own codes
// R11 - Write leaving maximum below minimum aborts with range-inversion code
// R12 - Storage failure aborts generic, or local-control or state specific
// R13 - Directory unavailable or not generated aborts with directory code
// R14 - Without oversampling only the newest record is shown each cycle
// R15 - With oversampling each cycle sends factor consecutive samples
// R16 - Base mapping index selects factor one
// R17 - Base plus one, two, three select factors two, four, eight
// R18 - All mapping objects assigned together share one factor
// R19 - A block is exposed only once every sample is written
// R20 - Filling continues while a block waits; unread blocks are replaced
// R21 - A slow-filling block is presented again in later cycles
// R22 - Master should cycle faster and detect duplicates by counter
module fbo_framer #(
    parameter int TIMEOUT_CYCLES = fbo_pkg::TIMEOUT_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sample_valid,
    input wire logic [fbo_pkg::SAMPLE_W-1:0] sample_data,
    input wire logic map_load,
    input wire logic [1:0] map_sel_a,
    input wire logic [1:0] map_sel_b,
    input wire logic map_two,
    input wire logic bus_cycle,
    output logic [fbo_pkg::MAX_OVS*fbo_pkg::SAMPLE_W-1:0] block_data,
    output logic [3:0] block_count,
    output logic [31:0] block_seq,
    output logic block_valid,
    output logic map_reject,
    input wire logic req_start,
    input wire logic req_segment,
    input wire logic req_toggle,
    input wire logic req_done,
    input wire logic [fbo_pkg::ERR_W-1:0] req_fault,
    output logic abort_valid,
    output logic [31:0] abort_code
);
    import fbo_pkg::*;

    // A zero limit would wrap the unsigned compare to all ones, so transfers would never time out
    if (TIMEOUT_CYCLES < 1) begin : g_bad_timeout
        $error("TIMEOUT_CYCLES must be positive");
    end

    typedef struct packed {
        logic [1:0] sel;
        logic [2:0] fill;
        logic [MAX_OVS*SAMPLE_W-1:0] work;
        logic [MAX_OVS*SAMPLE_W-1:0] done;
        logic [3:0] count;
        logic [31:0] seq;
        logic have;
        logic out_valid;
        logic [MAX_OVS*SAMPLE_W-1:0] out_data;
        logic [3:0] out_count;
        logic [31:0] out_seq;
        logic reject;
        logic busy;
        logic last_tog;
        logic [31:0] tmr;
        logic ab_valid;
        logic [31:0] ab_code;
    } fbo_state_t;

    fbo_state_t s_reg, s_next;

    function automatic logic [3:0] ovs_of(input logic [1:0] sel);
        ovs_of = 4'h1 << sel; // R16 R17
    endfunction : ovs_of

    function automatic logic [31:0] code_of(input logic [ERR_W-1:0] f);
        logic [31:0] c;
        c = 32'h0;
        // Lowest-numbered cause wins
        for (int i = ERR_W - 1; i >= 0; i--) begin
            if (f[i]) begin
                case (fbo_err_t'(i))
                    E_TOGGLE: c = AB_TOGGLE; // R2
                    E_TIMEOUT: c = AB_TIMEOUT; // R3
                    E_ACCESS: c = AB_ACCESS; // R4
                    E_READ_WO: c = AB_READ_WO; // R4
                    E_WRITE_RO: c = AB_WRITE_RO; // R4
                    E_NO_OBJ: c = AB_NO_OBJ; // R5
                    E_NOT_MAP: c = AB_NOT_MAP; // R6
                    E_MAP_LEN: c = AB_MAP_LEN; // R6
                    E_HW: c = AB_HW; // R7
                    E_LEN: c = AB_LEN; // R8
                    E_LONG: c = AB_LONG; // R8
                    E_SHORT: c = AB_SHORT; // R8
                    E_NO_SUB: c = AB_NO_SUB; // R9
                    E_VALUE: c = AB_VALUE; // R10
                    E_HIGH: c = AB_HIGH; // R10
                    E_LOW: c = AB_LOW; // R10
                    E_MAXMIN: c = AB_MAXMIN; // R11
                    E_STORE: c = AB_STORE; // R12
                    E_LOCAL: c = AB_LOCAL; // R12
                    E_STATE: c = AB_STATE; // R12
                    default: c = AB_DIR; // R13
                endcase
            end
        end
        code_of = c;
    endfunction : code_of

    // Reset pair sits outside the state struct: it has its own reset
    logic rst_meta_reg;
    logic rst_sync_reg;
    logic rst_sync_n;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    assign rst_sync_n = rst_sync_reg;

    logic [3:0] ovs;
    logic tog_err;
    logic tmo;
    logic [ERR_W-1:0] fault_all;
    assign ovs = ovs_of(s_reg.sel);
    assign tog_err = s_reg.busy && req_segment && (req_toggle == s_reg.last_tog);
    assign tmo = s_reg.busy && (s_reg.tmr >= TIMEOUT_CYCLES - 1);
    always_comb begin
        fault_all = req_fault;
        fault_all[E_TOGGLE] = req_fault[E_TOGGLE] | tog_err; // R2
        fault_all[E_TIMEOUT] = req_fault[E_TIMEOUT] | tmo; // R3
    end

    always_comb begin
        s_next = s_reg;
        s_next.ab_valid = 1'b0;
        s_next.reject = 1'b0;
        if (map_load) begin
            if (map_two && map_sel_a != map_sel_b) begin
                s_next.reject = 1'b1; // R18
            end else begin
                s_next.sel = map_sel_a; // R16 R17
                s_next.fill = 3'h0;
                s_next.have = 1'b0;
            end
        end else if (sample_valid) begin
            s_next.work[s_reg.fill*SAMPLE_W +: SAMPLE_W] = sample_data; // R15
            if ({1'b0, s_reg.fill} == ovs - 4'h1) begin
                s_next.done = s_next.work; // R19 R20 R14
                s_next.count = ovs;
                s_next.seq = s_reg.seq + 32'h1;
                s_next.have = 1'b1;
                s_next.fill = 3'h0;
            end else begin
                s_next.fill = s_reg.fill + 3'h1;
            end
        end
        if (bus_cycle && s_reg.have) begin
            s_next.out_data = s_reg.done; // R21
            s_next.out_count = s_reg.count;
            s_next.out_seq = s_reg.seq;
            s_next.out_valid = 1'b1;
        end
        if (req_start) begin
            s_next.busy = 1'b1;
            s_next.tmr = 32'h0;
            s_next.last_tog = 1'b1;
        end else if (s_reg.busy) begin
            s_next.tmr = s_reg.tmr + 32'h1;
            if (req_segment) s_next.last_tog = req_toggle;
            if (|fault_all) begin
                s_next.ab_valid = 1'b1; // R1
                s_next.ab_code = code_of(fault_all);
                s_next.busy = 1'b0;
            end else if (req_done) begin
                s_next.busy = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            s_reg.sel <= SEL_RST;
            s_reg.fill <= '0;
            s_reg.work <= '0;
            s_reg.done <= '0;
            s_reg.count <= '0;
            s_reg.seq <= '0;
            s_reg.have <= 1'b0;
            s_reg.out_valid <= 1'b0;
            s_reg.out_data <= '0;
            s_reg.out_count <= '0;
            s_reg.out_seq <= '0;
            s_reg.reject <= 1'b0;
            s_reg.busy <= 1'b0;
            s_reg.last_tog <= 1'b0;
            s_reg.tmr <= '0;
            s_reg.ab_valid <= 1'b0;
            s_reg.ab_code <= '0;
        end else begin
            s_reg.sel <= s_next.sel;
            s_reg.fill <= s_next.fill;
            s_reg.work <= s_next.work;
            s_reg.done <= s_next.done;
            s_reg.count <= s_next.count;
            s_reg.seq <= s_next.seq;
            s_reg.have <= s_next.have;
            s_reg.out_valid <= s_next.out_valid;
            s_reg.out_data <= s_next.out_data;
            s_reg.out_count <= s_next.out_count;
            s_reg.out_seq <= s_next.out_seq;
            s_reg.reject <= s_next.reject;
            s_reg.busy <= s_next.busy;
            s_reg.last_tog <= s_next.last_tog;
            s_reg.tmr <= s_next.tmr;
            s_reg.ab_valid <= s_next.ab_valid;
            s_reg.ab_code <= s_next.ab_code;
        end
    end

    assign block_data = s_reg.out_data;
    assign block_count = s_reg.out_count;
    assign block_seq = s_reg.out_seq;
    assign block_valid = s_reg.out_valid;
    assign map_reject = s_reg.reject;
    assign abort_valid = s_reg.ab_valid;
    assign abort_code = s_reg.ab_code;

    chk_abort_has_code: assert property ( // R1
        @(posedge clk) disable iff (!rst_sync_n)
        abort_valid |-> abort_code != 32'h0)
        else $error("abort without code");
    chk_toggle_code: assert property ( // R2
        @(posedge clk) disable iff (!rst_sync_n)
        (tog_err && !req_start) |=> abort_valid && abort_code == AB_TOGGLE)
        else $error("toggle abort missing");
    chk_timeout_code: assert property ( // R3
        @(posedge clk) disable iff (!rst_sync_n)
        (tmo && !req_start && req_fault == '0 && !tog_err)
        |=> abort_valid && abort_code == AB_TIMEOUT)
        else $error("timeout abort missing");
    chk_fault_abort: assert property ( // R5
        @(posedge clk) disable iff (!rst_sync_n)
        (s_reg.busy && !req_start && req_fault == (1 << E_NO_OBJ)
         && !tog_err && !tmo)
        |=> abort_valid && abort_code == AB_NO_OBJ)
        else $error("absent object code wrong");
    chk_block_full: assert property ( // R19
        @(posedge clk) disable iff (!rst_sync_n)
        $changed(s_reg.seq)
        |-> $past(sample_valid && !map_load
                  && {1'b0, s_reg.fill} == ovs - 4'h1))
        else $error("partial block exposed");
    chk_block_count: assert property ( // R15
        @(posedge clk) disable iff (!rst_sync_n)
        (bus_cycle && s_reg.have) |=> block_count == $past(s_reg.count))
        else $error("block count wrong");
    chk_repeat_block: assert property ( // R21
        @(posedge clk) disable iff (!rst_sync_n)
        (bus_cycle && s_reg.have && s_reg.out_valid
         && s_reg.seq == s_reg.out_seq)
        |=> block_valid && $stable(block_seq))
        else $error("block not repeated");
    chk_map_consistent: assert property ( // R18
        @(posedge clk) disable iff (!rst_sync_n)
        (map_load && map_two && map_sel_a != map_sel_b)
        |=> map_reject && $stable(s_reg.sel))
        else $error("inconsistent mapping taken");
    chk_map_taken: assert property ( // R18
        @(posedge clk) disable iff (!rst_sync_n)
        (map_load && !(map_two && map_sel_a != map_sel_b))
        |=> !map_reject && s_reg.sel == $past(map_sel_a))
        else $error("consistent mapping refused");
    chk_factor_sel: assert property ( // R16 R17
        @(posedge clk) disable iff (!rst_sync_n)
        ovs == (s_reg.sel == 2'h0 ? 4'h1 : s_reg.sel == 2'h1 ? 4'h2 :
                s_reg.sel == 2'h2 ? 4'h4 : 4'h8))
        else $error("factor does not match mapping");
    // Factor one keeps only the newest record
    chk_newest_kept: assert property ( // R14
        @(posedge clk) disable iff (!rst_sync_n)
        (sample_valid && !map_load && ovs == 4'h1)
        |=> s_reg.have && s_reg.done[SAMPLE_W-1:0] == $past(sample_data))
        else $error("newest record not kept");
    chk_write_ro_code: assert property ( // R4
        @(posedge clk) disable iff (!rst_sync_n)
        (s_reg.busy && !req_start && req_fault == (1 << E_WRITE_RO)
         && !tog_err && !tmo)
        |=> abort_valid && abort_code == AB_WRITE_RO)
        else $error("read-only write code wrong");
    chk_done_quiet: assert property ( // R1
        @(posedge clk) disable iff (!rst_sync_n)
        (s_reg.busy && !req_start && req_done && fault_all == '0)
        |=> !abort_valid && !s_reg.busy)
        else $error("clean transfer aborted");
endmodule : fbo_framer

// ==== test/fbo_master.sv ====
`timescale 1ns/10ps
module fbo_master (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic poll,
    input wire logic slow,
    input wire logic [31:0] block_seq,
    output logic bus_cycle,
    output logic pick,
    output logic dup
);
    logic [2:0] wait_reg;
    logic busy_reg;
    logic seen_reg;
    logic [31:0] last_reg;
    // A slow master lets extra cycles pass before its pickup
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_reg <= 3'h0;
            busy_reg <= 1'b0;
            seen_reg <= 1'b0;
            last_reg <= 32'h0;
            bus_cycle <= 1'b0;
            pick <= 1'b0;
        end else begin
            bus_cycle <= 1'b0;
            pick <= bus_cycle;
            if (poll) begin
                busy_reg <= 1'b1;
                wait_reg <= slow ? 3'h3 : 3'h0;
            end else if (busy_reg && wait_reg == 3'h0) begin
                busy_reg <= 1'b0;
                bus_cycle <= 1'b1;
            end else if (busy_reg) begin
                wait_reg <= wait_reg - 3'h1;
            end
            if (pick) begin
                seen_reg <= 1'b1;
                last_reg <= block_seq;
            end
        end
    end
    // Unchanged counter marks a repeated block
    assign dup = pick && seen_reg && (block_seq === last_reg);
endmodule : fbo_master

// ==== test/fieldbus_oversampling_sdo_abort_test.sv ====
`timescale 1ns/10ps
module fieldbus_oversampling_sdo_abort_test;
    import fbo_pkg::*;
    typedef struct {logic [255:0] d; logic [3:0] c; logic u;} fbo_exp_t;
    localparam logic [31:0] REJ = 32'hFFFF_FFFF;
    logic clk, rst_n, sample_valid, map_load, map_two, bus_cycle, poll, slow;
    logic req_start, req_segment, req_toggle, req_done, pick, dup;
    logic block_valid, map_reject, abort_valid, fresh;
    logic [31:0] sample_data, block_seq, abort_code, lf, got;
    logic [1:0] map_sel_a, map_sel_b;
    logic [255:0] block_data, exp_w, blk, m;
    logic [3:0] block_count;
    logic [ERR_W-1:0] req_fault;
    logic [31:0] eq[$];
    fbo_exp_t bq[$];
    fbo_exp_t e;
    int fails, total_checks, f, fill;
    logic [31:0] codes[21] = '{AB_TOGGLE, AB_TIMEOUT, AB_ACCESS, AB_READ_WO,
        AB_WRITE_RO, AB_NO_OBJ, AB_NOT_MAP, AB_MAP_LEN, AB_HW, AB_LEN,
        AB_LONG, AB_SHORT, AB_NO_SUB, AB_VALUE, AB_HIGH, AB_LOW, AB_MAXMIN,
        AB_STORE, AB_LOCAL, AB_STATE, AB_DIR};
    fbo_framer #(.TIMEOUT_CYCLES(20)) u_dut (.clk(clk), .rst_n(rst_n),
        .sample_valid(sample_valid), .sample_data(sample_data),
        .map_load(map_load), .map_sel_a(map_sel_a), .map_sel_b(map_sel_b),
        .map_two(map_two), .bus_cycle(bus_cycle), .block_data(block_data),
        .block_count(block_count), .block_seq(block_seq),
        .block_valid(block_valid), .map_reject(map_reject),
        .req_start(req_start), .req_segment(req_segment),
        .req_toggle(req_toggle), .req_done(req_done), .req_fault(req_fault),
        .abort_valid(abort_valid), .abort_code(abort_code));
    fbo_master u_master (.clk(clk), .rst_n(rst_n), .poll(poll), .slow(slow),
        .block_seq(block_seq), .bus_cycle(bus_cycle), .pick(pick), .dup(dup));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    task automatic chk(input logic [255:0] ex, input logic [255:0] g);
        total_checks++;
        if (g !== ex) begin
            fails++;
            $display("[ERR] %0t exp %h got %h", $time, ex, g);
        end
    endtask : chk
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : test_done
    task automatic tick();
        @(posedge clk);
        #1;
    endtask : tick
    task automatic samples(input int n);
        for (int i = 0; i < n; i++) begin
            tick();
            sample_valid = 1'b1;
            lf = lfsr(lf);
            sample_data = lf;
            exp_w[fill*32 +: 32] = lf;
            fill++;
            if (fill == f) begin
                blk = exp_w;
                fill = 0;
                fresh = 1'b1;
            end
        end
        tick();
        sample_valid = 1'b0;
    endtask : samples
    task automatic pollm(input logic s);
        tick();
        poll = 1'b1;
        slow = s;
        bq.push_back('{blk, 4'(f), ~fresh});
        fresh = 1'b0;
        tick();
        poll = 1'b0;
        repeat (8) tick();
    endtask : pollm
    task automatic setmap(input int a, input int b, input logic two);
        tick();
        map_load = 1'b1;
        map_sel_a = 2'(a);
        map_sel_b = 2'(b);
        map_two = two;
        if (two && a != b) begin
            eq.push_back(REJ);
        end else begin
            f = 1 << a;
            fill = 0;
        end
        tick();
        map_load = 1'b0;
    endtask : setmap
    task automatic xfer(input logic [ERR_W-1:0] bits, input logic [31:0] c);
        tick();
        req_start = 1'b1;
        tick();
        req_start = 1'b0;
        req_fault = bits;
        eq.push_back(c);
        tick();
        req_fault = '0;
        repeat (3) tick();
    endtask : xfer
    always @(negedge clk) begin
        if (abort_valid === 1'b1 || map_reject === 1'b1) begin
            got = (map_reject === 1'b1) ? REJ : abort_code;
            chk(eq.size() ? eq.pop_front() : 32'hDEAD_DEAD, got);
        end
        if (pick === 1'b1) begin
            if (bq.size() > 0) e = bq.pop_front();
            else e = '{'0, 4'h0, 1'b0};
            m = {256{1'b1}} >> (256 - 32 * e.c);
            chk(e.d & m, block_data & m);
            chk(e.c, block_count);
            chk(e.u, dup);
            chk(1, block_valid);
        end
    end
    initial begin
        #100us;
        fails++;
        test_done();
    end
    initial begin
        {sample_valid, map_load, map_two, poll, slow, req_start} = '0;
        {req_segment, req_toggle, req_done, fresh} = '0;
        {sample_data, map_sel_a, map_sel_b, req_fault, exp_w, blk} = '0;
        lf = 32'h0001_00B4;
        f = 1;
        fill = 0;
        rst_n = 1'b0;
        repeat (2) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (4) tick();
        samples(3);
        pollm(1'b0);
        for (int a = 1; a < 4; a++) begin
            setmap(a, a, 1'b1);
            samples(2 * f);
            pollm(a == 3);
        end
        pollm(1'b0);
        samples(f / 2);
        pollm(1'b0);
        samples(f / 2);
        setmap(1, 2, 1'b1);
        samples(8);
        pollm(1'b0);
        setmap(0, 0, 1'b0);
        samples(2);
        pollm(1'b1);
        for (int i = 0; i < 21; i++) xfer(21'(1) << i, codes[i]);
        xfer(21'h18, AB_READ_WO);
        tick();
        req_start = 1'b1;
        tick();
        {req_start, req_segment} = 2'b01;
        tick();
        eq.push_back(AB_TOGGLE);
        tick();
        req_segment = 1'b0;
        repeat (3) tick();
        req_start = 1'b1;
        tick();
        {req_start, req_segment} = 2'b01;
        tick();
        req_toggle = 1'b1;
        tick();
        {req_segment, req_toggle, req_done} = 3'b001;
        tick();
        req_done = 1'b0;
        repeat (3) tick();
        req_start = 1'b1;
        eq.push_back(AB_TIMEOUT);
        tick();
        req_start = 1'b0;
        repeat (30) tick();
        chk(0, eq.size() + bq.size());
        test_done();
    end
endmodule : fieldbus_oversampling_sdo_abort_test
